/* byte_queue.sv */
`timescale 1ns/10ps
`default_nettype none

module byte_queue
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 66,
  parameter int CNT_W = 7
)
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Flush
  input  wire logic             clear,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // Occupancy
  output logic      [CNT_W-1:0] count
);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [CNT_W-1:0] wr_ptr_ff;    // Write index
  logic [CNT_W-1:0] rd_ptr_ff;    // Read index
  logic [CNT_W-1:0] cnt_ff;       // Stored words
  logic             push;         // Word accepted
  logic             pop;          // Word removed

  assign in_ready  = (cnt_ff != CNT_W'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rd_ptr_ff];
  assign count     = cnt_ff;
  assign push      = in_valid && in_ready && !clear;
  assign pop       = out_valid && out_ready && !clear;

  // Wraps an index at the end of storage
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] p);
    bump = (p == CNT_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Storage write
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end
    else if (clear)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= bump(wr_ptr_ff);
      if (pop)
        rd_ptr_ff <= bump(rd_ptr_ff);
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule

`default_nettype wire

/* spi_fifo_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_fifo_monitor
(
  // Clock, reset, pins
  input wire logic                        core_clk,
  input wire logic                        rstn,
  input wire logic                        sck,
  input wire logic                        nss_n,
  input wire logic                        miso_o,
  input wire logic                        miso_oe,
  // Register side, mode, status
  input wire spi_fifo_pkg::reg_req_t      reg_req,
  input wire spi_fifo_pkg::op_mode_t      op_mode,
  input wire logic                        overflow_clear,
  input wire spi_fifo_pkg::queue_status_t queue_status,
  input wire logic                        frame_transmitted,
  input wire logic                        pattern_hit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Address of the last register write
  logic [6:0] wa_ff;
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      wa_ff <= 7'h00;
    else if (reg_req.we)
      wa_ff <= reg_req.addr;
  // Mode steps that flush the queue
  sequence s_tx_exit;
    $past(op_mode) == spi_fifo_pkg::MODE_TX && op_mode != spi_fifo_pkg::MODE_TX;
  endsequence
  sequence s_rx_entry;
    $past(op_mode) != spi_fifo_pkg::MODE_RX && op_mode == spi_fifo_pkg::MODE_RX;
  endsequence
  sequence s_rx_to_tx;
    $past(op_mode) == spi_fifo_pkg::MODE_RX && op_mode == spi_fifo_pkg::MODE_TX;
  endsequence
  property p_oe_off; nss_n [*6] |-> !miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
  property p_oe_on; !nss_n [*6] |-> miso_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("data out not driven in frame");
  property p_miso_hold; sck [*3] ##0 miso_oe |-> $stable(miso_o); endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("data out moved while clock high");
  property p_we_gap; reg_req.we |=> !reg_req.we [*8]; endproperty
  a_we_gap: assert property (p_we_gap) else $error("write pulses too close");
  property p_we_inc; reg_req.we |-> ##[1:8] reg_req.addr == wa_ff + 7'h01; endproperty
  a_we_inc: assert property (p_we_inc) else $error("address not stepped");
  property p_we_noq; reg_req.we |-> reg_req.addr != spi_fifo_pkg::QUEUE_ADDR; endproperty
  a_we_noq: assert property (p_we_noq) else $error("queue byte sent to registers");
  property p_ovf_clr; overflow_clear |-> ##[1:4] !queue_status.overflow && !queue_status.has_data; endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow clear failed");
  property p_tx_flush; s_tx_exit |-> ##[1:4] !queue_status.has_data; endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("queue kept after transmit");
  property p_rx_flush; s_rx_entry |-> ##[1:4] !queue_status.has_data; endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("queue kept entering receive");
  property p_rxtx_flush; s_rx_to_tx |-> ##[1:4] !queue_status.has_data; endproperty
  a_rxtx_flush: assert property (p_rxtx_flush) else $error("queue kept going to transmit");
  property p_ftx; (op_mode != spi_fifo_pkg::MODE_TX) [*4] |-> !frame_transmitted; endproperty
  a_ftx: assert property (p_ftx) else $error("sent flag outside transmit");
  property p_hit; (op_mode != spi_fifo_pkg::MODE_RX) [*4] |-> !pattern_hit; endproperty
  a_hit: assert property (p_hit) else $error("pattern hit outside receive");
endmodule
bind spi_register_fifo_sync_detect spi_fifo_monitor u_spi_fifo_monitor (.core_clk, .rstn, .sck,
  .nss_n, .miso_o, .miso_oe, .reg_req, .op_mode, .overflow_clear, .queue_status,
  .frame_transmitted, .pattern_hit);
`default_nettype wire

/* spi_fifo_pkg.sv */
package spi_fifo_pkg;

  // Serial port framing
  localparam int          BYTE_BITS     = 8;
  localparam int          ADDR_BITS     = 7;
  localparam int          DIR_BIT_POS   = 7;
  localparam logic        DIR_WRITE     = 1'b1;
  localparam logic [6:0]  QUEUE_ADDR    = 7'h00;
  localparam logic [7:0]  EMPTY_READ    = 8'h00;

  // Data queue geometry and reset values
  localparam int          QUEUE_DEPTH   = 66;
  localparam int          QUEUE_CNT_W   = 7;
  localparam logic [6:0]  THRESH_RESET  = 7'h0F;

  // Pattern detector geometry
  localparam int          PATTERN_BITS  = 64;
  localparam int          LEN_W         = 3;
  localparam int          TOL_W         = 3;

  // Pin synchroniser depth
  localparam int          SYNC_STAGES   = 3;

  // Operating modes
  typedef enum logic [2:0]
  {
    MODE_SLEEP,
    MODE_STDBY,
    MODE_FS,
    MODE_TX,
    MODE_RX
  } op_mode_t;

  // Register access towards the configuration store
  typedef struct packed
  {
    logic                 we;
    logic [6:0]           addr;
    logic [7:0]           wdata;
  } reg_req_t;

  // Queue status flags
  typedef struct packed
  {
    logic                 has_data;
    logic                 at_capacity;
    logic                 overflow;
    logic                 above_threshold;
  } queue_status_t;

endpackage

/* spi_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
(
  // Clock and serial pins
  input  wire logic core_clk,
  output logic      sck,
  output logic      nss_n,
  output logic      mosi,
  input  wire logic miso
);
  // Idle: clock low, deselected
  initial
  begin
    sck = 1'b0;
    nss_n = 1'b1;
    mosi = 1'b0;
  end
  // Half a serial clock period, four core cycles
  task automatic half();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  // Select change; data line scrambled once released
  task automatic sel(input logic lvl);
    half();
    nss_n = lvl;
    if (lvl)
      mosi = ~mosi;
    half();
  endtask
  // One byte both ways, most significant bit first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      half();
      sck = 1'b1;
      rx[i] = miso;
      half();
      sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* spi_register_fifo_sync_detect.sv */
`timescale 1ns/10ps
`default_nettype none

module spi_register_fifo_sync_detect
#(
  parameter int DEPTH = spi_fifo_pkg::QUEUE_DEPTH
)
(
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // Serial port pins
  input  wire logic                      sck,
  input  wire logic                      nss_n,
  input  wire logic                      mosi,
  output logic                           miso_o,
  output logic                           miso_oe,
  // Configuration register store
  output spi_fifo_pkg::reg_req_t         reg_req,
  input  wire logic [7:0]                reg_rdata,
  // Operating mode and settings
  input  wire spi_fifo_pkg::op_mode_t    op_mode,
  input  wire logic [6:0]                queue_threshold,
  input  wire logic                      overflow_clear,
  input  wire logic                      pattern_detect_enable,
  input  wire logic [2:0]                pattern_length,
  input  wire logic [2:0]                pattern_error_tolerance,
  input  wire logic [63:0]               pattern_value,
  // Modem bit stream
  input  wire logic                      bit_clk,
  input  wire logic                      rx_bit,
  output logic                           tx_bit,
  // Status
  output spi_fifo_pkg::queue_status_t    queue_status,
  output logic                           frame_transmitted,
  output logic                           pattern_hit
);

  localparam int CW = spi_fifo_pkg::QUEUE_CNT_W;
  localparam int NP = 5;  // Synchronised pins

  // Pin synchronisers: sck, nss_n, mosi, bit_clk, rx_bit
  logic [NP-1:0] s1_ff;   // First stage
  logic [NP-1:0] s2_ff;   // Second stage
  logic [NP-1:0] s3_ff;   // Third stage
  logic [NP-1:0] lvl_ff;  // Agreed level
  logic [NP-1:0] rise;    // Agreed rising change
  logic [NP-1:0] fall;    // Agreed falling change

  // Serial port state
  logic [2:0]    bit_cnt_ff;   // Bit within byte
  logic [7:0]    rx_sr_ff;     // Incoming byte
  logic [7:0]    tx_sr_ff;     // Outgoing byte
  logic          addr_done_ff; // Address byte received
  logic          write_ff;     // Direction of frame
  logic [6:0]    addr_ff;      // Current register address
  logic          load_ff;      // Reply byte fetch pending
  logic          peek_ff;      // Reply byte taken from queue head
  logic          miso_ff;      // Data-out bit
  logic          in_frame;     // Select asserted
  logic [7:0]    byte_in;      // Completed byte
  logic          byte_done;    // Byte completes this cycle

  // Queue connections
  logic          q_in_valid;
  logic          q_in_ready;
  logic [7:0]    q_in_data;
  logic          q_out_valid;
  logic          q_out_ready;
  logic [7:0]    q_out_data;
  logic [CW-1:0] q_count;
  logic          q_clear;
  logic          spi_push;     // Host writes queue
  logic          spi_pop;      // Host reads queue
  logic          rx_push;      // Receiver writes queue
  logic          tx_pop;       // Transmitter reads queue

  // Flags
  logic          has_data_ff;
  logic          overflow_ff;
  logic          level_ff;
  logic          level_stuck_ff;
  logic          q_access_ff;  // Queue touched last cycle
  logic          hit_ff;
  logic          sent_ff;
  logic          empty_d_ff;   // Queue empty last cycle

  // Modem shifters
  spi_fifo_pkg::op_mode_t mode_ff;  // Previous mode
  logic [2:0]    mbit_cnt_ff;  // Bit within modem byte
  logic [7:0]    mrx_sr_ff;    // Receive assembly
  logic          mrx_ready_ff; // Assembled byte waiting
  logic [7:0]    mrx_byte_ff;  // Assembled byte
  logic [7:0]    mtx_sr_ff;    // Transmit serialiser
  logic          mtx_busy_ff;  // Serialiser holds a byte
  logic          tx_bit_ff;    // Modulator bit
  logic [63:0]   hist_ff;      // Received bit history
  logic          is_rx;
  logic          is_tx;

  // Counts set bits of a vector
  function automatic logic [6:0] ones(input logic [63:0] v);
    logic [6:0] n;
    n = '0;
    for (int i = 0; i < spi_fifo_pkg::PATTERN_BITS; i++)
      n = n + 7'(v[i]);
    ones = n;
  endfunction

  // Bit mask covering the programmed pattern length
  function automatic logic [63:0] len_mask(input logic [2:0] len);
    len_mask = ~64'h0 >> (7'(spi_fifo_pkg::PATTERN_BITS) - 7'({len, 3'b000}) - 7'h08);
  endfunction

  // Three-stage synchronisers; level taken once stages two and three agree
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_ff  <= 5'h02;
      s2_ff  <= 5'h02;
      s3_ff  <= 5'h02;
      lvl_ff <= 5'h02;
    end
    else
    begin
      s1_ff <= {rx_bit, bit_clk, mosi, nss_n, sck};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < NP; i++)
        if (s2_ff[i] == s3_ff[i])
          lvl_ff[i] <= s3_ff[i];
    end
  end

  // Edges of the agreed levels
  always_comb
  begin
    for (int i = 0; i < NP; i++)
    begin
      rise[i] = (s2_ff[i] == s3_ff[i]) && s3_ff[i] && !lvl_ff[i];
      fall[i] = (s2_ff[i] == s3_ff[i]) && !s3_ff[i] && lvl_ff[i];
    end
  end

  assign in_frame  = !lvl_ff[1];
  assign byte_in   = {rx_sr_ff[6:0], lvl_ff[2]};
  assign byte_done = in_frame && rise[0] && (bit_cnt_ff == 3'h7);

  // Receive side of the serial port: bits, address and direction
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bit_cnt_ff   <= '0;
      rx_sr_ff     <= '0;
      addr_done_ff <= 1'b0;
      write_ff     <= 1'b0;
      addr_ff      <= '0;
    end
    else if (!in_frame || fall[1])
    begin
      // Frame ended or starting: expect an address byte
      bit_cnt_ff   <= '0;
      addr_done_ff <= 1'b0;
    end
    else if (rise[0])
    begin
      rx_sr_ff   <= byte_in;
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
      if (byte_done && !addr_done_ff)
      begin
        // Address byte: direction then seven address bits
        addr_done_ff <= 1'b1;
        write_ff     <= (byte_in[spi_fifo_pkg::DIR_BIT_POS] == spi_fifo_pkg::DIR_WRITE);
        addr_ff      <= byte_in[6:0];
      end
      else if (byte_done && addr_ff != spi_fifo_pkg::QUEUE_ADDR)
      begin
        addr_ff <= addr_ff + 1'b1;
      end
    end
  end

  // Register store write strobe, address and data
  always_comb
  begin
    reg_req.addr  = addr_ff;
    reg_req.wdata = byte_in;
    reg_req.we    = byte_done && addr_done_ff && write_ff
                    && (addr_ff != spi_fifo_pkg::QUEUE_ADDR);
  end

  // Host queue access; address stays on the queue
  assign spi_push = byte_done && addr_done_ff && write_ff
                    && (addr_ff == spi_fifo_pkg::QUEUE_ADDR);
  // Head leaves only once the host clocked the whole byte out, so a frame
  // ending after its last byte does not swallow the next queued byte
  assign spi_pop  = byte_done && addr_done_ff && peek_ff && !write_ff
                    && (addr_ff == spi_fifo_pkg::QUEUE_ADDR);

  // Reply byte: fetched one cycle after a byte ends, shifted out on falling edges
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      load_ff  <= 1'b0;
      peek_ff  <= 1'b0;
      tx_sr_ff <= '0;
      miso_ff  <= 1'b0;
    end
    else
    begin
      load_ff <= byte_done;
      if (!in_frame)
      begin
        tx_sr_ff <= '0;
        miso_ff  <= 1'b0;
        peek_ff  <= 1'b0;
      end
      else if (load_ff)
      begin
        // Register read shows contents before any write of this byte
        peek_ff  <= q_out_valid && (addr_ff == spi_fifo_pkg::QUEUE_ADDR);
        if (addr_ff == spi_fifo_pkg::QUEUE_ADDR)
          tx_sr_ff <= q_out_valid ? q_out_data : spi_fifo_pkg::EMPTY_READ;
        else
          tx_sr_ff <= reg_rdata;
      end
      else if (fall[0])
      begin
        miso_ff  <= tx_sr_ff[7];
        tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
      end
    end
  end

  // Slave-only data-out, released while deselected
  assign miso_o  = miso_ff;
  assign miso_oe = in_frame;

  assign is_rx = (op_mode == spi_fifo_pkg::MODE_RX);
  assign is_tx = (op_mode == spi_fifo_pkg::MODE_TX);

  // Queue flush on leaving transmit, on entering receive or on receive to transmit, or on overflow clear
  always_comb
  begin
    q_clear = overflow_clear;
    if (op_mode != mode_ff)
    begin
      if (mode_ff == spi_fifo_pkg::MODE_TX)
        q_clear = 1'b1;
      else if (is_rx && mode_ff != spi_fifo_pkg::MODE_RX)
        q_clear = 1'b1;
      else if (is_tx && mode_ff == spi_fifo_pkg::MODE_RX)
        q_clear = 1'b1;
    end
  end

  // Queue writer and reader selection; host first on write, host or serialiser pops on read
  assign q_in_valid  = spi_push || rx_push;
  assign q_in_data   = spi_push ? byte_in : mrx_byte_ff;
  assign rx_push     = mrx_ready_ff && !spi_push;
  assign q_out_ready = spi_pop || tx_pop;

  byte_queue
  #(
    .WIDTH (spi_fifo_pkg::BYTE_BITS),
    .DEPTH (DEPTH),
    .CNT_W (CW)
  )
  u_queue
  (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .clear     (q_clear),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (q_in_data),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out_data),
    .count     (q_count)
  );

  // Queue flags
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      has_data_ff    <= 1'b0;
      overflow_ff    <= 1'b0;
      level_ff       <= 1'b0;
      level_stuck_ff <= 1'b0;
      q_access_ff    <= 1'b0;
      empty_d_ff     <= 1'b1;
    end
    else
    begin
      // Held during a host queue read, refreshed at select falling
      if (!(in_frame && addr_done_ff && !write_ff
            && addr_ff == spi_fifo_pkg::QUEUE_ADDR) || fall[1])
        has_data_ff <= (q_count != '0);
      // Write into a full queue: byte dropped, flag set; set beats clear
      if (q_in_valid && !q_in_ready)
        overflow_ff <= 1'b1;
      else if (overflow_clear)
        overflow_ff <= 1'b0;
      q_access_ff <= q_in_valid || q_out_ready;
      empty_d_ff  <= (q_count == '0);
      // Level frozen once full until the queue drains
      if (q_count == CW'(DEPTH))
        level_stuck_ff <= 1'b1;
      else if (q_count == '0)
        level_stuck_ff <= 1'b0;
      if (q_access_ff && (!level_stuck_ff || q_count == '0))
        level_ff <= (q_count > queue_threshold);
    end
  end

  always_comb
  begin
    queue_status.has_data        = has_data_ff;
    queue_status.at_capacity     = (q_count == CW'(DEPTH));
    queue_status.overflow        = overflow_ff;
    queue_status.above_threshold = level_ff;
  end

  // Receive and transmit serialiser clocked by modem bit edges
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_ff      <= spi_fifo_pkg::MODE_SLEEP;
      mbit_cnt_ff  <= '0;
      mrx_sr_ff    <= '0;
      mrx_ready_ff <= 1'b0;
      mrx_byte_ff  <= '0;
      mtx_sr_ff    <= '0;
      mtx_busy_ff  <= 1'b0;
      tx_bit_ff    <= 1'b0;
      hist_ff      <= '0;
    end
    else
    begin
      mode_ff <= op_mode;
      if (rx_push)
        mrx_ready_ff <= 1'b0;
      if (op_mode != mode_ff)
      begin
        mbit_cnt_ff <= '0;
        mtx_busy_ff <= 1'b0;
      end
      else if (is_rx && rise[3])
      begin
        // Assemble demodulated bits, gated by a pattern hit when detection is on
        hist_ff   <= {hist_ff[62:0], lvl_ff[4]};
        mrx_sr_ff <= {mrx_sr_ff[6:0], lvl_ff[4]};
        if (!pattern_detect_enable || hit_ff)
        begin
          mbit_cnt_ff <= mbit_cnt_ff + 1'b1;
          if (mbit_cnt_ff == 3'h7)
          begin
            mrx_byte_ff  <= {mrx_sr_ff[6:0], lvl_ff[4]};
            mrx_ready_ff <= 1'b1;
          end
        end
      end
      else if (is_tx && rise[3])
      begin
        // Serialise most significant bit first
        if (mbit_cnt_ff == 3'h0 && q_out_valid)
        begin
          tx_bit_ff   <= q_out_data[7];
          mtx_sr_ff   <= {q_out_data[6:0], 1'b0};
          mtx_busy_ff <= 1'b1;
          mbit_cnt_ff <= 3'h1;
        end
        else if (mbit_cnt_ff != 3'h0)
        begin
          tx_bit_ff   <= mtx_sr_ff[7];
          mtx_sr_ff   <= {mtx_sr_ff[6:0], 1'b0};
          mbit_cnt_ff <= mbit_cnt_ff + 1'b1;
        end
        else
        begin
          mtx_busy_ff <= 1'b0;
        end
      end
    end
  end

  assign tx_pop = is_tx && (op_mode == mode_ff) && rise[3]
                  && (mbit_cnt_ff == 3'h0) && q_out_valid;
  assign tx_bit = tx_bit_ff;

  // Transmitted indication once the serialiser runs dry after its last bit
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sent_ff <= 1'b0;
    else if (is_tx && rise[3] && mbit_cnt_ff == 3'h0 && !q_out_valid && mtx_busy_ff)
      sent_ff <= 1'b1;
    else if (!is_tx)
      sent_ff <= 1'b0;
  end

  assign frame_transmitted = sent_ff;

  // Pattern match over the last (length+1)*8 bits, within the error tolerance
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      hit_ff <= 1'b0;
    else if (pattern_detect_enable && is_rx && !hit_ff && rise[3]
             && ones(({hist_ff[62:0], lvl_ff[4]}
                      ^ (pattern_value >> (7'(spi_fifo_pkg::PATTERN_BITS)
                                          - 7'({pattern_length, 3'b000}) - 7'h08)))
                     & len_mask(pattern_length))
                <= 7'(pattern_error_tolerance))
      hit_ff <= 1'b1;
    else if (!is_rx || (q_count == '0 && !empty_d_ff))
      hit_ff <= 1'b0;
  end

  assign pattern_hit = hit_ff;

endmodule

`default_nettype wire

/* tb_spi_register_fifo_sync_detect.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_spi_register_fifo_sync_detect;
  // Pins, settings and model state
  logic core_clk = 1'b0, rstn = 1'b0, overflow_clear = 1'b0, bit_clk = 1'b0, rx_bit = 1'b0;
  logic pattern_detect_enable = 1'b0, miso_o, miso_oe, tx_bit, frame_transmitted, pattern_hit;
  wire logic sck, nss_n, mosi, miso;
  spi_fifo_pkg::op_mode_t      op_mode = spi_fifo_pkg::MODE_STDBY;
  spi_fifo_pkg::reg_req_t      reg_req;
  spi_fifo_pkg::queue_status_t queue_status;
  logic [7:0]   reg_rdata, rx, d, mem[128], regs_m[128], q[$], txd[$], rxd[$], ex[$];
  logic [6:0]   queue_threshold = 7'h0F;
  logic [2:0]   pattern_length = 3'h0, pattern_error_tolerance = 3'h0;
  logic [63:0]  pattern_value = 64'hB4C3_5A3C_9669_1E2D;
  logic [15:0]  lfsr = 16'h7B31;
  logic [255:0] txs = 256'h0;
  logic [14:0]  wq[$];
  int           error_cnt = 0, cmp_count = 0, hit;
  assign miso = miso_oe ? miso_o : 1'bz;
  always #10 core_clk = ~core_clk;
  spi_register_fifo_sync_detect u_spi_register_fifo_sync_detect (.core_clk, .rstn, .sck, .nss_n,
    .mosi, .miso_o, .miso_oe, .reg_req, .reg_rdata, .op_mode, .queue_threshold, .overflow_clear,
    .pattern_detect_enable, .pattern_length, .pattern_error_tolerance, .pattern_value, .bit_clk,
    .rx_bit, .tx_bit, .queue_status, .frame_transmitted, .pattern_hit);
  spi_host_model u_spi_host_model (.core_clk, .sck, .nss_n, .mosi, .miso);
  // Register store; logs every write
  assign reg_rdata = mem[reg_req.addr];
  always @(posedge core_clk)
    if (reg_req.we)
    begin
      mem[reg_req.addr] <= reg_req.wdata;
      wq.push_back({reg_req.addr, reg_req.wdata});
    end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Frame: address byte then n data bytes, from txd on a write and zero on a read; replies go to rxd
  task automatic frame(input logic w, input logic [6:0] a, input int n);
    rxd.delete();
    u_spi_host_model.sel(1'b0);
    u_spi_host_model.xfer({w, a}, rx);
    repeat (n)
    begin
      d = w ? txd.pop_front() : 8'h00;
      u_spi_host_model.xfer(d, rx);
      rxd.push_back(rx);
    end
    u_spi_host_model.sel(1'b1);
    cyc(8);
  endtask
  // Eight link clock periods; samples the modulator bit before each rise
  task automatic bits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      rx_bit = b[i];
      cyc(3);
      txs = {txs[254:0], tx_bit};
      bit_clk = 1'b1;
      cyc(4);
      bit_clk = 1'b0;
      cyc(1);
    end
  endtask
  initial
  begin
    for (int i = 0; i < 128; i++)
    begin
      mem[i] = 8'(i) ^ 8'h5A;
      regs_m[i] = 8'(i) ^ 8'h5A;
    end
    cyc(10);
    rstn = 1'b1;
    cyc(6);
    txd = {rnd(), rnd()};
    ex = txd;
    frame(1'b1, 7'h10, 2);
    for (int k = 0; k < 2; k++)
    begin
      chk(rxd[k], regs_m[16 + k]);
      chk({1'b0, wq[k][14:8]}, 8'(16 + k));
      chk(wq[k][7:0], ex[k]);
      regs_m[16 + k] = ex[k];
    end
    frame(1'b0, 7'h10, 3);
    for (int k = 0; k < 3; k++)
      chk(rxd[k], regs_m[16 + k]);
    $display("Register burst test done");
    wq.delete();
    for (int k = 0; k < 67; k++)
      txd.push_back(rnd());
    for (int k = 0; k < 66; k++)
      q.push_back(txd[k]);
    frame(1'b1, 7'h00, 15);
    chk(queue_status.above_threshold, 1'b0);
    frame(1'b1, 7'h00, 1);
    chk(queue_status.above_threshold, 1'b1);
    frame(1'b1, 7'h00, 50);
    chk(queue_status.at_capacity, 1'b1);
    chk(queue_status.overflow, 1'b0);
    frame(1'b1, 7'h00, 1);
    chk(queue_status.overflow, 1'b1);
    chk(8'(wq.size()), 8'h00);
    frame(1'b0, 7'h00, 3);
    for (int k = 0; k < 3; k++)
      chk(rxd[k], q.pop_front());
    chk(queue_status.at_capacity, 1'b0);
    overflow_clear = 1'b1;
    cyc(1);
    overflow_clear = 1'b0;
    cyc(6);
    chk(queue_status.overflow, 1'b0);
    chk(queue_status.has_data, 1'b0);
    frame(1'b0, 7'h00, 1);
    chk(rxd[0], spi_fifo_pkg::EMPTY_READ);
    $display("Queue fill test done");
    txd = {rnd(), rnd()};
    ex = txd;
    frame(1'b1, 7'h00, 2);
    op_mode = spi_fifo_pkg::MODE_TX;
    cyc(4);
    repeat (5)
      bits(8'h00);
    hit = 0;
    for (int i = 0; i < 25; i++)
      if (txs[i +: 16] == {ex[0], ex[1]})
        hit = 1;
    chk(8'(hit), 8'h01);
    chk(frame_transmitted, 1'b1);
    op_mode = spi_fifo_pkg::MODE_STDBY;
    cyc(6);
    chk(frame_transmitted, 1'b0);
    $display("Transmit test done");
    pattern_detect_enable = 1'b1;
    pattern_length = 3'h1;
    pattern_error_tolerance = 3'h1;
    txd = {8'h77};
    frame(1'b1, 7'h00, 1);
    op_mode = spi_fifo_pkg::MODE_RX;
    cyc(6);
    chk(queue_status.has_data, 1'b0);
    bits(8'h55);
    bits(8'h55);
    chk(pattern_hit, 1'b0);
    bits(8'hB4);
    chk(pattern_hit, 1'b0);
    bits(8'hC2);
    cyc(6);
    chk(pattern_hit, 1'b1);
    bits(8'h3C);
    cyc(6);
    op_mode = spi_fifo_pkg::MODE_STDBY;
    cyc(6);
    chk(pattern_hit, 1'b0);
    frame(1'b0, 7'h00, 1);
    chk(rxd[0], 8'h3C);
    op_mode = spi_fifo_pkg::MODE_RX;
    txd = {8'h5A};
    frame(1'b1, 7'h00, 1);
    chk(queue_status.has_data, 1'b1);
    op_mode = spi_fifo_pkg::MODE_TX;
    cyc(6);
    chk(queue_status.has_data, 1'b0);
    $display("Receive test done");
    summarize();
  end
  // Hang guard
  initial
  begin
    #2000000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
